// [logic/rtc_special_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_special_regs (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_ptr_load,
	input  wire logic       i_wr_strobe,
	input  wire logic       i_rd_strobe,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_alarm1_match,
	input  wire logic       i_alarm2_match,
	input  wire logic       i_osc_clk,
	input  wire logic       i_osc_fail,
	input  wire logic       i_on_backup,
	output logic      [7:0] o_rd_data,
	output logic            o_rd_valid,
	output logic      [7:0] o_pointer,
	output logic            o_osc_run,
	output logic            o_square_irq_pin_level,
	output logic            o_square_irq_pin_oe,
	output logic            o_charger_enable,
	output logic            o_charger_diode,
	output logic      [1:0] o_charger_resistor
);
	logic [7:0] control_q;
	logic [7:0] charger_q;
	logic       osc_stop_flag_q;
	logic       alarm2_flag_q;
	logic       alarm1_flag_q;
	logic       osc_disable_prev_q;
	logic       osc_fail_prev_q;
	logic       osc_level_prev_q;
	logic [2:0] pin_levels;
	logic       osc_level_s;
	logic       osc_fail_s;
	logic       on_backup_s;
	logic       square_wave;

	rtc_pin_sync u_sync (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_pins   ({i_on_backup, i_osc_fail, i_osc_clk}),
		.o_levels (pin_levels)
	);

	assign osc_level_s = pin_levels[0];
	assign osc_fail_s  = pin_levels[1];
	assign on_backup_s = pin_levels[2];

	// Control fields
	wire       osc_disable          = control_q[rtc_special_pkg::BIT_OSC_DISABLE];
	wire       backup_output_enable = control_q[rtc_special_pkg::BIT_BACKUP_OUT_EN];
	wire       rate_select_hi       = control_q[rtc_special_pkg::BIT_RATE_SELECT_HI];
	wire       rate_select_lo       = control_q[rtc_special_pkg::BIT_RATE_SELECT_LO];
	wire       irq_select           = control_q[rtc_special_pkg::BIT_IRQ_SELECT];
	wire       alarm2_irq_enable    = control_q[rtc_special_pkg::BIT_ALARM2_IRQ_EN];
	wire       alarm1_irq_enable    = control_q[rtc_special_pkg::BIT_ALARM1_IRQ_EN];

	// Charger fields
	wire [3:0] charger_key     = charger_q[7:4];
	wire [1:0] diode_select    = charger_q[3:2];
	wire [1:0] resistor_select = charger_q[1:0];

	// Access decode: pointer load wins, then write, then read
	wire sel_control = (o_pointer == rtc_special_pkg::ADDR_CONTROL);
	wire sel_status  = (o_pointer == rtc_special_pkg::ADDR_STATUS);
	wire sel_charger = (o_pointer == rtc_special_pkg::ADDR_CHARGER);
	wire wr_go       = i_wr_strobe && !i_ptr_load;
	wire rd_go       = i_rd_strobe && !i_ptr_load && !i_wr_strobe;
	wire wr_control  = wr_go && sel_control;
	wire wr_status   = wr_go && sel_status;
	wire wr_charger  = wr_go && sel_charger;

	wire [7:0] pointer_d = i_ptr_load ? i_wr_data :
		(wr_go || rd_go) ? 8'(o_pointer + 8'h01) : o_pointer;

	wire [7:0] control_d = wr_control ? (i_wr_data & rtc_special_pkg::CONTROL_WMASK) :
		control_q;
	wire [7:0] charger_d = wr_charger ? i_wr_data : charger_q;

	// Stop events: detector edge, or software stopping the oscillator
	wire osc_fail_rise   = osc_fail_s && !osc_fail_prev_q;
	wire disable_rise    = osc_disable && !osc_disable_prev_q;
	wire osc_rise        = osc_level_s && !osc_level_prev_q;
	wire osc_stop_clear  = wr_status && !i_wr_data[rtc_special_pkg::BIT_OSC_STOP_FLAG];
	wire alarm2_clear    = wr_status && !i_wr_data[rtc_special_pkg::BIT_ALARM2_FLAG];
	wire alarm1_clear    = wr_status && !i_wr_data[rtc_special_pkg::BIT_ALARM1_FLAG];

	// Set wins over a same-cycle clear; writing 1 changes nothing
	wire osc_stop_flag_d = (osc_fail_rise || disable_rise) ? 1'b1 :
		osc_stop_clear ? 1'b0 : osc_stop_flag_q;
	wire alarm2_flag_d   = i_alarm2_match ? 1'b1 :
		alarm2_clear ? 1'b0 : alarm2_flag_q;
	wire alarm1_flag_d   = i_alarm1_match ? 1'b1 :
		alarm1_clear ? 1'b0 : alarm1_flag_q;

	wire [7:0] status_view = {osc_stop_flag_q, 5'h00, alarm2_flag_q, alarm1_flag_q};

	// Addresses outside this block read as zero here
	wire [7:0] rd_mux = sel_control ? control_q :
		sel_status ? status_view :
		sel_charger ? charger_q : 8'h00;

	// Pin behaviour
	wire alarm2_irq = irq_select && alarm2_irq_enable && alarm2_flag_q;
	wire alarm1_irq = irq_select && alarm1_irq_enable && alarm1_flag_q;
	wire irq_active = alarm2_irq || alarm1_irq;
	wire pin_level_d = irq_select ? !irq_active : square_wave;
	// Tri-state of the pad is left to the pad ring; we only gate enable
	wire pin_oe_d    = !on_backup_s || backup_output_enable;

	wire charger_on  = (charger_key == rtc_special_pkg::CHARGER_KEY) &&
		((diode_select == rtc_special_pkg::DIODE_NONE) ||
		(diode_select == rtc_special_pkg::DIODE_ONE)) &&
		(resistor_select != rtc_special_pkg::RES_OFF);
	wire charger_diode_d = charger_on && (diode_select == rtc_special_pkg::DIODE_ONE);
	wire [1:0] charger_res_d = charger_on ? resistor_select : rtc_special_pkg::RES_OFF;

	rtc_square_divider u_divider (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_osc_level (osc_level_s),
		.i_osc_rise  (osc_rise),
		.i_rate      ({rate_select_hi, rate_select_lo}),
		.o_wave      (square_wave)
	);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			control_q <= rtc_special_pkg::CONTROL_RESET;
			charger_q <= rtc_special_pkg::CHARGER_RESET;
			o_pointer <= 8'h00;
		end else begin
			control_q <= control_d;
			charger_q <= charger_d;
			o_pointer <= pointer_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			osc_stop_flag_q <= rtc_special_pkg::OSF_RESET;
			alarm2_flag_q   <= 1'b0;
			alarm1_flag_q   <= 1'b0;
		end else begin
			osc_stop_flag_q <= osc_stop_flag_d;
			alarm2_flag_q   <= alarm2_flag_d;
			alarm1_flag_q   <= alarm1_flag_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			osc_disable_prev_q <= 1'b0;
			osc_fail_prev_q    <= 1'b0;
			osc_level_prev_q   <= 1'b0;
		end else begin
			osc_disable_prev_q <= osc_disable;
			osc_fail_prev_q    <= osc_fail_s;
			osc_level_prev_q   <= osc_level_s;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= rd_go;
			if (rd_go) begin
				o_rd_data <= rd_mux;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_osc_run              <= 1'b1;
			o_square_irq_pin_level <= 1'b1;
			o_square_irq_pin_oe    <= 1'b1;
			o_charger_enable       <= 1'b0;
			o_charger_diode        <= 1'b0;
			o_charger_resistor     <= rtc_special_pkg::RES_OFF;
		end else begin
			o_osc_run              <= !osc_disable;
			o_square_irq_pin_level <= pin_level_d;
			o_square_irq_pin_oe    <= pin_oe_d;
			o_charger_enable       <= charger_on;
			o_charger_diode        <= charger_diode_d;
			o_charger_resistor     <= charger_res_d;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	sequence disable_written;
		wr_control && i_wr_data[rtc_special_pkg::BIT_OSC_DISABLE];
	endsequence

	sequence alarm1_armed;
		i_alarm1_match && irq_select && alarm1_irq_enable && !wr_control;
	endsequence

	sequence alarm2_armed;
		i_alarm2_match && irq_select && alarm2_irq_enable && !wr_control;
	endsequence

	chk_osc_stop_cmd: assert property (disable_written |=> ##1 !o_osc_run)
		else $error("Oscillator still runs after disable write");
	chk_backup_float: assert property (
		(on_backup_s && !backup_output_enable) |=> !o_square_irq_pin_oe)
		else $error("Pin driven on backup without enable");
	chk_reset_values: assert property (disable iff (1'b0)
		i_rst |=> (control_q == 8'h18) && (charger_q == 8'h00) && osc_stop_flag_q)
		else $error("Wrong values after reset");
	chk_square_path: assert property (
		!irq_select |=> (o_square_irq_pin_level == $past(square_wave)))
		else $error("Square wave not on pin");
	chk_alarm1_pin: assert property (alarm1_armed |=> ##1 !o_square_irq_pin_level)
		else $error("Alarm 1 match did not drive the pin");
	chk_alarm2_pin: assert property (alarm2_armed |=> ##1 !o_square_irq_pin_level)
		else $error("Alarm 2 match did not drive the pin");
	chk_irq_gated: assert property (
		(irq_select && !alarm1_irq_enable && !alarm2_irq_enable) |=> o_square_irq_pin_level)
		else $error("Disabled alarm drove the pin");
	chk_osf_set: assert property ((osc_fail_rise || disable_rise) |=> osc_stop_flag_q)
		else $error("Stop flag missed a stop event");
	chk_osf_clear_only: assert property (
		(!osc_stop_flag_q && !osc_fail_rise && !disable_rise) |=> !osc_stop_flag_q)
		else $error("Stop flag set without a stop");
	chk_alarm_set_wins: assert property (
		(i_alarm1_match && i_alarm2_match) |=> (alarm1_flag_q && alarm2_flag_q))
		else $error("Alarm match lost");
	chk_alarm_clear: assert property (
		(alarm1_clear && !i_alarm1_match) |=> !alarm1_flag_q)
		else $error("Alarm 1 flag not cleared by zero");
	chk_flag_hold: assert property (
		(alarm2_flag_q && !alarm2_clear) |=> alarm2_flag_q)
		else $error("Alarm 2 flag dropped without clear");
	chk_charger_key: assert property (
		(charger_key != rtc_special_pkg::CHARGER_KEY) |=> !o_charger_enable)
		else $error("Charger on without key");
	chk_charger_path: assert property (
		charger_on |=> o_charger_enable && (o_charger_resistor == $past(resistor_select)) &&
		(o_charger_diode == ($past(diode_select) == 2'h2)))
		else $error("Charger path mismatch");
	chk_pointer_step: assert property (
		(wr_go || rd_go) |=> (o_pointer == 8'($past(o_pointer) + 8'h01)))
		else $error("Pointer did not advance");
	chk_unused_zero: assert property (
		(rd_go && (sel_status || sel_control)) |=> o_rd_valid && (o_rd_data[6] == 1'b0))
		else $error("Unused bit read as one");
endmodule
`default_nettype wire

// [logic/rtc_special_pkg.sv]
`default_nettype none
package rtc_special_pkg;
	// Register offsets, as printed
	localparam logic [7:0] ADDR_CONTROL = 8'h0e;
	localparam logic [7:0] ADDR_STATUS  = 8'h0f;
	localparam logic [7:0] ADDR_CHARGER = 8'h10;

	// Control field positions
	localparam int BIT_OSC_DISABLE    = 7;
	localparam int BIT_BACKUP_OUT_EN  = 5;
	localparam int BIT_RATE_SELECT_HI = 4;
	localparam int BIT_RATE_SELECT_LO = 3;
	localparam int BIT_IRQ_SELECT     = 2;
	localparam int BIT_ALARM2_IRQ_EN  = 1;
	localparam int BIT_ALARM1_IRQ_EN  = 0;

	// Status field positions
	localparam int BIT_OSC_STOP_FLAG = 7;
	localparam int BIT_ALARM2_FLAG   = 1;
	localparam int BIT_ALARM1_FLAG   = 0;

	// Values after reset
	localparam logic [7:0] CONTROL_RESET = 8'h18;
	localparam logic [7:0] CHARGER_RESET = 8'h00;
	localparam logic       OSF_RESET     = 1'h1;

	// Writable bits of control; bit 6 is unused
	localparam logic [7:0] CONTROL_WMASK = 8'hbf;

	// Charger encodings
	localparam logic [3:0] CHARGER_KEY = 4'ha;
	localparam logic [1:0] DIODE_NONE  = 2'h1;
	localparam logic [1:0] DIODE_ONE   = 2'h2;
	localparam logic [1:0] RES_OFF     = 2'h0;

	// Square-wave rate codes
	localparam logic [1:0] RATE_1HZ  = 2'h0;
	localparam logic [1:0] RATE_4K   = 2'h1;
	localparam logic [1:0] RATE_8K   = 2'h2;
	localparam logic [1:0] RATE_32K  = 2'h3;

	// Divider of oscillator edges
	localparam int DIV_WIDTH   = 15;
	localparam int DIV_BIT_1HZ = 14;
	localparam int DIV_BIT_4K  = 2;
	localparam int DIV_BIT_8K  = 1;
	localparam logic [DIV_WIDTH-1:0] DIV_RESET = 15'h0000;

	// Synchroniser width: number of pins carried
	localparam int SYNC_WIDTH = 3;
endpackage
`default_nettype wire

// [logic/rtc_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_pin_sync (
	input  wire logic                                  i_clock,
	input  wire logic                                  i_rst,
	input  wire logic [rtc_special_pkg::SYNC_WIDTH-1:0] i_pins,
	output logic      [rtc_special_pkg::SYNC_WIDTH-1:0] o_levels
);
	logic [rtc_special_pkg::SYNC_WIDTH-1:0] meta_q;
	logic [rtc_special_pkg::SYNC_WIDTH-1:0] mid_q;
	logic [rtc_special_pkg::SYNC_WIDTH-1:0] late_q;

	genvar b;
	generate
		for (b = 0; b < rtc_special_pkg::SYNC_WIDTH; b = b + 1) begin : g_bit
			// Change counts once second and third stages agree
			always_ff @(posedge i_clock) begin
				if (i_rst) begin
					meta_q[b]   <= 1'b0;
					mid_q[b]    <= 1'b0;
					late_q[b]   <= 1'b0;
					o_levels[b] <= 1'b0;
				end else begin
					meta_q[b] <= i_pins[b];
					mid_q[b]  <= meta_q[b];
					late_q[b] <= mid_q[b];
					if (mid_q[b] == late_q[b]) begin
						o_levels[b] <= late_q[b];
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [logic/rtc_square_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_square_divider (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_osc_level,
	input  wire logic       i_osc_rise,
	input  wire logic [1:0] i_rate,
	output logic            o_wave
);
	logic [rtc_special_pkg::DIV_WIDTH-1:0] count_q;
	logic                                  wave_d;

	assign wave_d = (i_rate == rtc_special_pkg::RATE_32K) ? i_osc_level :
		(i_rate == rtc_special_pkg::RATE_8K) ? count_q[rtc_special_pkg::DIV_BIT_8K] :
		(i_rate == rtc_special_pkg::RATE_4K) ? count_q[rtc_special_pkg::DIV_BIT_4K] :
		count_q[rtc_special_pkg::DIV_BIT_1HZ];

	// Stopped oscillator gives no edges, so the wave freezes too
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			count_q <= rtc_special_pkg::DIV_RESET;
			o_wave  <= 1'b0;
		end else begin
			if (i_osc_rise) begin
				count_q <= count_q + 15'h0001;
			end
			o_wave <= wave_d;
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	chk_rate_top_follow: assert property (
		(i_rate == rtc_special_pkg::RATE_32K) |=> (o_wave == $past(i_osc_level)))
		else $error("Top rate does not follow the oscillator");
	chk_rate_low_bit: assert property (
		(i_rate == rtc_special_pkg::RATE_1HZ) |=> (o_wave == $past(count_q[14])))
		else $error("1 Hz rate uses the wrong divider bit");
endmodule
`default_nettype wire

// [tb/rtc_reg_master.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_reg_master (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid,
	output var  logic       o_ptr_load,
	output var  logic       o_wr_strobe,
	output var  logic       o_rd_strobe,
	output var  logic [7:0] o_wr_data
);
	initial begin
		o_ptr_load = 1'b0;
		o_wr_strobe = 1'b0;
		o_rd_strobe = 1'b0;
		o_wr_data = 8'h00;
	end
	// First byte of a write sets the pointer
	task automatic point(input logic [7:0] a);
		@(posedge i_clock);
		o_ptr_load <= 1'b1;
		o_wr_data <= a;
		@(posedge i_clock);
		o_ptr_load <= 1'b0;
		o_wr_data <= ~a;
	endtask
	// Released data shows the inverse, not a stale byte
	task automatic put(input logic [7:0] v);
		@(posedge i_clock);
		o_wr_strobe <= 1'b1;
		o_wr_data <= v;
		@(posedge i_clock);
		o_wr_strobe <= 1'b0;
		o_wr_data <= ~v;
	endtask
	task automatic get(output logic [7:0] v, output logic ok);
		int n;
		ok = 1'b0;
		v = 8'h00;
		@(posedge i_clock);
		o_rd_strobe <= 1'b1;
		@(posedge i_clock);
		o_rd_strobe <= 1'b0;
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (i_rd_valid === 1'b1) begin
				ok = 1'b1;
				v = i_rd_data;
			end else begin
				@(posedge i_clock);
			end
		end
	endtask
endmodule
`default_nettype wire

// [tb/rtc_control_status_charger_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_control_status_charger_regs_bench;
	logic       i_clock, i_rst, ptr_load, wr_strobe, rd_strobe;
	logic [7:0] wr_data, rd_data, pointer;
	logic       a1, a2, osc, fail, backup, rd_valid, osc_run;
	logic       pin, pin_oe, ch_en, ch_diode;
	logic [1:0] ch_res, oc;
	int         error_cnt = 0;
	int         checks = 0;

	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// Slow oscillator stand-in: one period every 8 clocks
	always @(posedge i_clock) begin
		oc <= oc + 2'h1;
		if (oc == 2'h3) osc <= ~osc;
	end

	rtc_reg_master m (.i_clock(i_clock), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
		.o_ptr_load(ptr_load), .o_wr_strobe(wr_strobe), .o_rd_strobe(rd_strobe),
		.o_wr_data(wr_data));
	rtc_special_regs dut (.i_clock(i_clock), .i_rst(i_rst), .i_ptr_load(ptr_load),
		.i_wr_strobe(wr_strobe), .i_rd_strobe(rd_strobe), .i_wr_data(wr_data),
		.i_alarm1_match(a1), .i_alarm2_match(a2), .i_osc_clk(osc), .i_osc_fail(fail),
		.i_on_backup(backup), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
		.o_pointer(pointer), .o_osc_run(osc_run), .o_square_irq_pin_level(pin),
		.o_square_irq_pin_oe(pin_oe), .o_charger_enable(ch_en),
		.o_charger_diode(ch_diode), .o_charger_resistor(ch_res));

	task automatic wrap_up();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] exp);
		logic [7:0] v;
		logic       ok;
		m.get(v, ok);
		if (!ok) begin
			error_cnt++;
			wrap_up();
		end
		chk(v, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		m.point(a);
		m.put(v);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic pulse(input logic two);
		@(posedge i_clock);
		if (two) a2 <= 1'b1;
		else a1 <= 1'b1;
		@(posedge i_clock);
		a1 <= 1'b0;
		a2 <= 1'b0;
	endtask

	task automatic t_reset();
		settle(1);
		chk({osc_run, pin_oe, ch_en}, 8'h06);
		m.point(rtc_special_pkg::ADDR_CONTROL);
		rd(8'h18);
		rd(8'h80);
		rd(8'h00);
	endtask
	task automatic t_masks();
		wr(rtc_special_pkg::ADDR_CONTROL, 8'hff);
		m.put(8'hff);
		settle(2);
		chk({7'h00, osc_run}, 8'h00);
		m.point(rtc_special_pkg::ADDR_CONTROL);
		rd(8'hbf);
		rd(8'h80);
		wr(rtc_special_pkg::ADDR_STATUS, 8'h00);
		m.point(rtc_special_pkg::ADDR_STATUS);
		rd(8'h00);
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h18);
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h98);
		m.point(rtc_special_pkg::ADDR_STATUS);
		rd(8'h80);
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h18);
		wr(rtc_special_pkg::ADDR_STATUS, 8'h00);
		@(posedge i_clock);
		fail <= 1'b1;
		repeat (10) @(posedge i_clock);
		fail <= 1'b0;
		m.point(rtc_special_pkg::ADDR_STATUS);
		rd(8'h80);
		wr(rtc_special_pkg::ADDR_STATUS, 8'h00);
		m.point(8'h20);
		rd(8'h00);
		settle(1);
		chk(pointer, 8'h21);
	endtask
	task automatic t_alarm();
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h05);
		pulse(1'b0);
		settle(2);
		chk({7'h00, pin}, 8'h00);
		settle(8);
		chk({7'h00, pin}, 8'h00);
		pulse(1'b1);
		m.point(rtc_special_pkg::ADDR_STATUS);
		rd(8'h03);
		wr(rtc_special_pkg::ADDR_STATUS, 8'h02);
		settle(3);
		chk({7'h00, pin}, 8'h01);
		m.point(rtc_special_pkg::ADDR_STATUS);
		rd(8'h02);
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h06);
		settle(3);
		chk({7'h00, pin}, 8'h00);
		wr(rtc_special_pkg::ADDR_STATUS, 8'h00);
	endtask
	task automatic t_charger();
		logic [11:0] tbl [6] = '{12'ha5_9, 12'haa_e, 12'hab_f, 12'had_0, 12'ha8_0, 12'h5a_0};
		foreach (tbl[i]) begin
			wr(rtc_special_pkg::ADDR_CHARGER, tbl[i][11:4]);
			settle(2);
			chk({4'h0, ch_en, ch_diode, ch_res}, {4'h0, tbl[i][3:0]});
		end
	endtask
	task automatic t_backup();
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h18);
		backup <= 1'b1;
		settle(10);
		chk({7'h00, pin_oe}, 8'h00);
		wr(rtc_special_pkg::ADDR_CONTROL, 8'h38);
		settle(3);
		chk({7'h00, pin_oe}, 8'h01);
		backup <= 1'b0;
	endtask
	task automatic t_square();
		logic [7:0] ctl [3] = '{8'h18, 8'h10, 8'h08};
		int         div [3] = '{4, 16, 32};
		int         n;
		logic       last;
		foreach (ctl[i]) begin
			wr(rtc_special_pkg::ADDR_CONTROL, ctl[i]);
			settle(80);
			n = 0;
			last = pin;
			repeat (256) begin
				settle(1);
				if (pin !== last) n++;
				last = pin;
			end
			// Edge alignment may shift the count by one
			chk(8'((n - 256 / div[i] + 1) / 3), 8'h00);
		end
	endtask

	initial begin
		i_rst = 1'b1;
		a1 = 1'b0;
		a2 = 1'b0;
		osc = 1'b0;
		oc = 2'h0;
		fail = 1'b0;
		backup = 1'b0;
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		t_reset();
		t_masks();
		t_alarm();
		t_charger();
		t_backup();
		t_square();
		wrap_up();
	end
endmodule
`default_nettype wire
